/* File: bench/pac_host_model.sv */
// Purpose: Controller model that loads and reads the pixel store.
// Assumes: One byte per strobe; read data one cycle after the strobe.
// Notes: Drives its request just after the rising edge.
`default_nettype none
module pac_host_model (
   input wire logic clk,
   output var pac_pkg::pac_req_t req,
   input wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import pac_pkg::*;

   // Idle port at power-up.
   initial begin
      req = '0;
   end

   // Fill pattern: pixel bytes per address, column bytes cover all codes.
   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[10] ? {~a[3:0], a[3:0]} : a[7:0] ^ {7'h2d, a[8]};
   endfunction

   // One write; released lines show the inverse, not the old value.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= {a, d, 2'b10};
      @(posedge clk);
      req <= {~a, ~d, 2'b00};
   endtask

   // One read; data is taken one cycle after the strobe.
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= {a, 8'h00, 2'b01};
      @(posedge clk);
      req <= {~a, 8'hff, 2'b00};
      #1 d = rdata;
   endtask

   // Volatile stores are rewritten in full after power-up.
   task automatic load_all;
      for (int a = 0; a < 16'h0420; a++) begin
         if (a < 16'h0200 || a >= 16'h0400) wr(a[15:0], pat(a[15:0]));
      end
   endtask
endmodule
`default_nettype wire

/* File: bench/tb_pixel_array_config.sv */
// Purpose: Self-checking bench for the pixel array store.
// Assumes: The host model speaks the byte register port.
// Notes: Mode table first, then pins, map, readback, refusals and reset.
`default_nettype none
module tb_pixel_array_config;
   timeunit 1ns;
   timeprecision 1ps;
   import pac_pkg::*;
   logic clk;
   logic rstn;
   logic ce;
   logic qa;
   logic qb;
   pac_req_t req;
   logic [7:0] rdata;
   logic [7:0] d;
   logic [7:0] e;
   logic [63:0][63:0] px;
   pac_route_t [63:0] cr;
   pac_quad_t dout;
   pac_quad_t doe;
   pac_quad_t aoe;
   logic [15:0] a;
   logic [3:0] nib;
   int err_count = 0;
   int comparisons = 0;
   // Rows: output control byte, digital enables, analog enables.
   logic [15:0] rows [5] = '{16'h000f, 16'h10f0, 16'h90a0, 16'h800f,
      16'h9fa0};

   pac_pixel_array_config uut (.clk(clk), .rstn(rstn), .ce(ce), .req(req),
      .rdata(rdata), .quad_a_raw(qa), .quad_b_raw(qb), .pixel_active(px),
      .col_route(cr), .dig_out(dout), .dig_oe(doe), .ana_oe(aoe));
   pac_host_model host (.clk(clk), .req(req), .rdata(rdata));

   // Free-running clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic check(input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Cuts a hang short.
   initial begin
      #(40000 * 25);
      err_count++;
      test_done;
   end

   // Main sequence.
   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      qa = 1'b0;
      qb = 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      #1 check({4'h0, aoe}, 8'h0f);
      for (int i = 0; i < 5; i++) begin
         host.wr(16'h0884, rows[i][15:8]);
         #1 check({4'h0, doe}, {4'h0, rows[i][7:4]});
         check({4'h0, aoe}, {4'h0, rows[i][3:0]});
      end
      $display("test output modes done");
      host.wr(16'h0884, 8'h10);
      qa <= 1'b1;
      repeat (3) @(posedge clk);
      #1 check({4'h0, dout}, 8'h09);
      qb <= 1'b1;
      repeat (3) @(posedge clk);
      #1 check({4'h0, dout}, 8'h0a);
      $display("test differential pins done");
      host.load_all;
      @(posedge clk);
      #1;
      for (int r = 0; r < 64; r++) begin
         for (int c = 0; c < 64; c++) begin
            a = {7'h00, r[5:0], c[3], c[5:4]};
            e = host.pat(a);
            check(8'(px[r][c]), 8'(e[c[2:0]]));
         end
      end
      for (int c = 0; c < 64; c++) begin
         a = 16'h0400 + c[15:1];
         e = host.pat(a);
         nib = c[0] ? e[7:4] : e[3:0];
         check(8'(cr[c]), (nib < 4'h6) ? 8'(nib) : 8'h07);
      end
      $display("test pixel and column map done");
      for (int i = 0; i < 16'h0420; i++) begin
         if (i < 16'h0200 || i >= 16'h0400) begin
            host.rd(i[15:0], d);
            check(d, host.pat(i[15:0]));
         end
      end
      $display("test readback done");
      @(posedge clk);
      ce <= 1'b0;
      host.wr(16'h0000, 8'hff);
      ce <= 1'b1;
      host.wr(16'h0420, 8'h55);
      host.rd(16'h0000, d);
      check(d, host.pat(16'h0000));
      host.rd(16'h0420, d);
      check(d, 8'h00);
      host.rd(16'h0200, d);
      check(d, 8'h00);
      host.wr(16'h0001, 8'h3c);
      host.rd(16'h0001, d);
      check(d, 8'h3c);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      host.rd(16'h0884, d);
      check(d, 8'h00);
      check({4'h0, doe}, 8'h00);
      check({4'h0, aoe}, 8'h0f);
      host.rd(16'h0001, d);
      check(d, 8'h3c);
      $display("test refusals and reset done");
      test_done;
   end
endmodule
`default_nettype wire

/* File: verilog/pac_col_route.sv */
// Purpose: Decode one column nibble into its aggregate destination.
// Assumes: Nibble comes straight from the column store.
// Notes: Purely combinational.
`default_nettype none
module pac_col_route (
   input wire logic [3:0] nibble,
   output pac_pkg::pac_route_t route
);
   import pac_pkg::*;

   // Codes 0 to 5 pick an aggregate; every other code shunts to ground.
   assign route = (nibble <= 4'h5) ? pac_route_t'(nibble[2:0]) : PAC_GND;
endmodule
`default_nettype wire

/* File: verilog/pac_pixel_array_config.sv */
// Purpose: Pixel enable and column route store with quadrature pin drive.
// Assumes: Register port is the byte engine behind the serial port.
// Notes: Pixel and column stores have no reset; they are volatile.
// Notes: The controller must reload both stores after power returns.
// Notes: Negative digital levels keep toggling while their pins float.
// Functional notes
// - Rows numbered zero top to 63 bottom.
// - Column groups left to right 0,4,1,5,2,6,3,7.
// - Pixel byte address is row then group.
// - Bit zero is leftmost pixel of eight.
// - Enabled pixel feeds its column's aggregate.
// - Disabled pixel is shunted to ground.
// - Low nibble left column, high nibble right.
// - Column bytes step left to right upward.
// - Nibble codes pick aggregate, others ground.
// - Differential negative pins invert positive pins.
// - Single-ended mode floats negative digital pins.
// - Digital mode floats all analog pins.
// - Analog mode floats all digital pins.
// - Type bit analog/digital, style bit differential/single.
`default_nettype none
`include "pac_pixel_map.svh"
module pac_pixel_array_config (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire pac_pkg::pac_req_t req,
   output logic [7:0] rdata,
   input wire logic quad_a_raw,
   input wire logic quad_b_raw,
   output logic [63:0][63:0] pixel_active,
   output pac_pkg::pac_route_t [63:0] col_route,
   output pac_pkg::pac_quad_t dig_out,
   output pac_pkg::pac_quad_t dig_oe,
   output pac_pkg::pac_quad_t ana_oe
);
   import pac_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Storage.
   // The two volatile stores; no reset, contents stand until power fails.
   logic [7:0] pix_mem [`PAC_PIX_BYTES];
   logic [7:0] col_mem [`PAC_COL_BYTES];
   logic [7:0] qcfg_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic qa_s1_q, qa_s2_q, qb_s1_q, qb_s2_q;
   pac_quad_t dig_q;

   ////////////////////////////////////////////////////////////////////////
   // Address decode; a pixel hit needs all bits above the row field to be zero.
   wire pix_hit = (req.addr[15:9] == 7'h00);
   wire col_hit = (req.addr[15:5] == 11'(`PAC_COL_BASE >> 5));
   wire qcfg_hit = (req.addr == `PAC_QCFG_ADDR);
   wire [8:0] pix_idx = req.addr[8:0];
   wire [4:0] col_idx = req.addr[4:0];

   // Mode bits of the output control register.
   wire output_type_select = qcfg_q[`PAC_QCFG_TYPE_BIT];
   wire output_style_select = qcfg_q[`PAC_QCFG_STYLE_BIT];

   // Read data selection; unmapped addresses return zero.
   // A read and a write in one cycle return the old byte.
   always_comb begin
      if (pix_hit) begin
         rdata_d = pix_mem[pix_idx];
      end else if (col_hit) begin
         rdata_d = col_mem[col_idx];
      end else if (qcfg_hit) begin
         rdata_d = qcfg_q;
      end else begin
         rdata_d = 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pixel store: written only, never reset, so contents survive rstn.
   always_ff @(posedge clk) begin
      if (ce && req.wr && pix_hit) begin
         pix_mem[pix_idx] <= req.wdata;
      end
   end

   // Column store, two column nibbles per byte.
   always_ff @(posedge clk) begin
      if (ce && req.wr && col_hit) begin
         col_mem[col_idx] <= req.wdata;
      end
   end

   // Output mode register and registered read data.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         qcfg_q <= `PAC_QCFG_RESET;
         rdata_q <= 8'h00;
      end else if (ce) begin
         if (req.wr && qcfg_hit) begin
            qcfg_q <= req.wdata;
         end
         if (req.rd) begin
            rdata_q <= rdata_d;
         end
      end
   end
   assign rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Pixel map: physical position p maps to group {p[0], p[2:1]}.
   genvar r, c;
   generate
      for (r = 0; r < `PAC_ROWS; r++) begin : g_row
         for (c = 0; c < `PAC_COLS; c++) begin : g_col
            localparam logic [2:0] POS = 3'(c / `PAC_GRP_COLS);
            localparam logic [2:0] GRP = {POS[0], POS[2:1]};
            // Row number sits above the three group bits of the address.
            localparam int IDX = r * 8 + int'(GRP);
            // A set bit joins the column aggregate, a clear bit grounds.
            assign pixel_active[r][c] =
               pix_mem[IDX][c % `PAC_GRP_COLS];
         end
      end
      for (c = 0; c < `PAC_COLS; c++) begin : g_route
         // Even column takes the low nibble, odd column the high one.
         pac_col_route u_dec (
            .nibble(col_mem[c / 2][(c % 2) * 4 +: 4]),
            .route(col_route[c])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Comparator levels cross in through two flops before use.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         qa_s1_q <= 1'b0;
         qa_s2_q <= 1'b0;
         qb_s1_q <= 1'b0;
         qb_s2_q <= 1'b0;
      end else if (ce) begin
         qa_s1_q <= quad_a_raw;
         qa_s2_q <= qa_s1_q;
         qb_s1_q <= quad_b_raw;
         qb_s2_q <= qb_s1_q;
      end
   end

   // Digital pin levels; negatives are always complements.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         dig_q <= '{a_pos: 1'b0, a_neg: 1'b1, b_pos: 1'b0, b_neg: 1'b1};
      end else if (ce) begin
         dig_q.a_pos <= qa_s2_q;
         dig_q.a_neg <= ~qa_s2_q;
         dig_q.b_pos <= qb_s2_q;
         dig_q.b_neg <= ~qb_s2_q;
      end
   end
   assign dig_out = dig_q;

   // Pin enables follow the type and style bits; high means driven.
   wire neg_drive = output_type_select && !output_style_select;
   assign dig_oe.a_pos = output_type_select;
   assign dig_oe.b_pos = output_type_select;
   assign dig_oe.a_neg = neg_drive;
   assign dig_oe.b_neg = neg_drive;
   assign ana_oe = output_type_select ? 4'h0 : 4'hf;

   ////////////////////////////////////////////////////////////////////////
   // Checks on the pin drive pattern.
   dig_neg_inv_a: assert property (@(posedge clk) disable iff (!rstn)
      (output_type_select && !output_style_select) |->
      (dig_out.a_neg == !dig_out.a_pos && dig_out.b_neg == !dig_out.b_pos))
      else $error("negative digital pin is not the complement");
   se_neg_float_a: assert property (@(posedge clk) disable iff (!rstn)
      (output_type_select && output_style_select) |->
      (!dig_oe.a_neg && !dig_oe.b_neg && dig_oe.a_pos && dig_oe.b_pos))
      else $error("single-ended drive pattern wrong");
   ana_float_a: assert property (@(posedge clk) disable iff (!rstn)
      output_type_select |-> (ana_oe == 4'h0))
      else $error("analog pin driven in digital mode");
   dig_float_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && req.wr && qcfg_hit && !req.wdata[`PAC_QCFG_TYPE_BIT]) |=>
      (dig_oe == 4'h0 && ana_oe == 4'hf))
      else $error("digital pin driven in analog mode");

   // Reset lands the port in analog mode with settled digital levels.
   reset_state_a: assert property (@(posedge clk)
      !rstn |=> (qcfg_q == `PAC_QCFG_RESET && rdata == 8'h00 &&
      dig_oe == 4'h0 && ana_oe == 4'hf && dig_out == 4'h5))
      else $error("reset state of the pin drive is wrong");

   // Checks on the stores and the read port.
   byte_readback_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && req.wr && (pix_hit || col_hit)) ##1 (ce && !req.wr) ##1
      (ce && req.rd && !req.wr && req.addr == $past(req.addr, 2)) |=>
      (rdata == $past(req.wdata, 3)))
      else $error("store byte did not read back");

   // Read data stands until the next accepted read strobe.
   rdata_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      !(ce && req.rd) |=> $stable(rdata))
      else $error("read data changed without a read");
   unmapped_read_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && req.rd && req.addr == 16'h0200) |=> (rdata == 8'h00))
      else $error("unmapped address returned data");

   // Checks on the pixel and column maps.
   group_order_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && req.wr && req.addr == 16'h0004) |=>
      (pixel_active[0][15:8] == $past(req.wdata)))
      else $error("group four is not second from left");
   last_row_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && req.wr && req.addr == `PAC_PIX_LAST) |=>
      (pixel_active[63][63] == $past(req.wdata[7])))
      else $error("bottom right pixel mismapped");
   col_route_a: assert property (@(posedge clk) disable iff (!rstn)
      (ce && req.wr && req.addr == `PAC_COL_LAST &&
      req.wdata == 8'h0f) |=>
      (col_route[63] == PAC_A_POS && col_route[62] == PAC_GND))
      else $error("rightmost column pair route wrong");
endmodule
`default_nettype wire

/* File: verilog/pac_pixel_map.svh */
// Purpose: Address, field and reset constants of the pixel array store.
// Assumes: Byte-wide register port with a 16-bit byte address.
// Notes: Definitions only.
`ifndef PAC_PIXEL_MAP_SVH
`define PAC_PIXEL_MAP_SVH

`define PAC_PIX_BASE 16'h0000
`define PAC_PIX_LAST 16'h01ff
`define PAC_COL_BASE 16'h0400
`define PAC_COL_LAST 16'h041f
`define PAC_QCFG_ADDR 16'h0884
`define PAC_QCFG_RESET 8'h00
`define PAC_QCFG_TYPE_BIT 4
`define PAC_QCFG_STYLE_BIT 7
`define PAC_ROWS 64
`define PAC_COLS 64
`define PAC_GRP_COLS 8
`define PAC_PIX_BYTES 512
`define PAC_COL_BYTES 32

`endif

/* File: verilog/pac_pkg.sv */
// Purpose: Types shared by the pixel array store.
// Assumes: Nothing beyond the map header.
// Notes: Route codes match the column nibble encoding.
`default_nettype none
package pac_pkg;

   // Aggregate destination of one column.
   typedef enum logic [2:0] {
      PAC_A_POS = 3'h0,
      PAC_A_NEG = 3'h1,
      PAC_B_POS = 3'h2,
      PAC_B_NEG = 3'h3,
      PAC_Z_POS = 3'h4,
      PAC_Z_NEG = 3'h5,
      PAC_GND = 3'h7
   } pac_route_t;

   // One set of four quadrature pins.
   typedef struct packed {
      logic a_pos;
      logic a_neg;
      logic b_pos;
      logic b_neg;
   } pac_quad_t;

   // Register port request.
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pac_req_t;

endpackage
`default_nettype wire
